// ===== bpss_bus_filter.sv
// Low-voltage filter: flags the bus low only after a continuous low time.
// Assumes a synchronised low flag on the system clock.
`timescale 1ns/1ns
`include "bpss_regs.svh"
module bpss_bus_filter #(
    parameter int FILTER_CYC = `BPSS_BUS_FILTER_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic busLow, // bus below threshold, synchronised
    output logic busLost // low held for the full filter time
);
    localparam int CW = $clog2(FILTER_CYC + 1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_busLost;

    initial begin
        if (FILTER_CYC < 1) begin
            $error("bpss_bus_filter: FILTER_CYC must be at least 1");
        end
    end

    always_comb begin
        next_count = count;
        next_busLost = busLost;
        if (srst || !busLow) begin
            next_count = '0;
            next_busLost = 1'b0;
        end else if (count == CW'(FILTER_CYC - 1)) begin
            next_busLost = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        count <= next_count;
        busLost <= next_busLost;
    end
endmodule

// ===== bpss_checker.sv
// Port assertions of the bus power state sequencer.
// Assumes inputs reach the outputs in three edges (two sync stages, one register).
`timescale 1ns/1ns
`include "bpss_regs.svh"
module bpss_checker #(
    parameter int BUS_FILTER_CYC = 20
) (
    input wire logic clk_sys, // clock
    input wire logic srst, // reset
    input wire logic busVoltageOk, // watched
    input wire logic filteredAbove14v, // watched
    input wire logic filteredAbove12v, // watched
    input wire logic thermalWarning, // watched
    input wire logic thermalShutdown, // watched
    input wire logic hostClockSelect, // watched
    input wire logic adjBuckEnable_n, // watched
    input wire logic auxRegEnable_n, // watched
    input wire logic hostReset_n_o, // watched
    input wire logic hostReset_n_oe, // watched
    input wire logic powerWarning_n_o, // watched
    input wire logic powerWarning_n_oe, // watched
    input wire logic fixedBuckOn, // watched
    input wire logic adjustableBuckOn, // watched
    input wire logic auxRegOn, // watched
    input wire logic [1:0] hostClockSel, // watched
    input wire logic commActive // watched
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    int lowCnt;
    int next_lowCnt;
    // Counts raw bus-low cycles, saturating past the filter time
    always_comb begin
        next_lowCnt = lowCnt;
        if (busVoltageOk) next_lowCnt = 0;
        else if (lowCnt < BUS_FILTER_CYC + 8) next_lowCnt = lowCnt + 1;
    end
    always_ff @(posedge clk_sys) begin
        if (srst) lowCnt <= 0;
        else lowCnt <= next_lowCnt;
    end
    sequence s_tsdHeld;
        thermalShutdown [*4];
    endsequence
    sequence s_auxOff;
        $rose(auxRegEnable_n) ##1 auxRegEnable_n [*2];
    endsequence
    a_shutdown_forces_reset: assert property (s_tsdHeld |-> hostReset_n_oe && !fixedBuckOn && !commActive
        && hostClockSel == `BPSS_CLKSEL_OFF) else $error("thermal shutdown did not force reset");
    a_twarn_warns: assert property (thermalWarning [*4] |-> powerWarning_n_oe)
        else $error("thermal warning left warning pin released");
    a_low14_warns: assert property (!filteredAbove14v [*4] |-> powerWarning_n_oe)
        else $error("low filtered supply left warning released");
    a_low12_resets: assert property (!filteredAbove12v [*4] |-> hostReset_n_oe)
        else $error("supply below 12 V left host reset released");
    a_od_never_high: assert property (hostReset_n_o == 1'b0 && powerWarning_n_o == 1'b0)
        else $error("open-drain output drives high");
    a_adj_gate_off: assert property (adjBuckEnable_n [*4] |-> !adjustableBuckOn)
        else $error("adjustable buck on while its enable is high");
    a_aux_gate_off: assert property (s_auxOff |-> ##1 !auxRegOn)
        else $error("20 V regulator on while its enable is high");
    a_bus_loss_warns: assert property (lowCnt >= BUS_FILTER_CYC + 6 |-> powerWarning_n_oe)
        else $error("long bus loss left warning released");
    a_comm_with_clock: assert property (commActive |-> fixedBuckOn && hostClockSel != `BPSS_CLKSEL_OFF)
        else $error("communication active without clock or fixed rail");
    a_normal_clock: assert property ($stable(hostClockSelect) [*4] ##0 !powerWarning_n_oe
        |-> hostClockSel == (hostClockSelect ? `BPSS_CLKSEL_16M : `BPSS_CLKSEL_8M))
        else $error("normal host clock does not follow select");
endmodule
bind bpss_sequencer bpss_checker #(.BUS_FILTER_CYC(BUS_FILTER_CYC)) u_bpss_checker (.clk_sys, .srst,
    .busVoltageOk, .filteredAbove14v, .filteredAbove12v, .thermalWarning, .thermalShutdown, .hostClockSelect,
    .adjBuckEnable_n, .auxRegEnable_n, .hostReset_n_o, .hostReset_n_oe, .powerWarning_n_o, .powerWarning_n_oe,
    .fixedBuckOn, .adjustableBuckOn, .auxRegOn, .hostClockSel, .commActive);

// ===== bpss_host_model.sv
// Host controller model: pull-ups on the reset and warning pins, strapped clock select.
// Assumes the device only pulls the pins low.
`timescale 1ns/1ns
module bpss_host_model (
    input wire logic wantFast, // host wants the fast clock
    input wire logic resetOe, // device pulls reset
    input wire logic resetVal, // reset pin value when pulled
    input wire logic warnOe, // device pulls warning
    input wire logic warnVal, // warning pin value when pulled
    output logic hostClockSelect, // low 8 MHz, high 16 MHz
    output logic hostReset_n, // resolved reset pin
    output logic powerWarning_n, // resolved warning pin
    output logic hostRunning // host may talk to the device
);
    assign hostClockSelect = wantFast;
    assign hostReset_n = resetOe ? resetVal : 1'b1;
    assign powerWarning_n = warnOe ? warnVal : 1'b1;
    assign hostRunning = hostReset_n;
endmodule

// ===== bpss_pkg.sv
// Types of the bus power state sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package bpss_pkg;
    typedef enum logic [2:0] {
        ST_RESET,
        ST_STARTUP,
        ST_STANDBY,
        ST_NORMAL
    } state_type;
    typedef enum logic [1:0] {
        LIM_LOW,
        LIM_HIGH,
        LIM_RES
    } limit_type;
endpackage

// ===== bpss_regs.svh
// Constants of the bus power state sequencer: timing counts and strap codes.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef BPSS_REGS_SVH
`define BPSS_REGS_SVH
`define BPSS_CLK_MHZ 100
`define BPSS_BUS_FILTER_US 2000
`define BPSS_BUS_FILTER_CYC (`BPSS_BUS_FILTER_US * `BPSS_CLK_MHZ)
`define BPSS_SLOPE_LOW 2'h0
`define BPSS_SLOPE_HIGH 2'h1
`define BPSS_SLOPE_RES 2'h2
`define BPSS_SLOPE_X10_LOW 8'h05
`define BPSS_SLOPE_X10_HIGH 8'h0a
`define BPSS_STARTUP_MA_LOW 8'h1e
`define BPSS_STARTUP_MA_HIGH 8'h3c
`define BPSS_BUDGET_X10_LOW 8'h6a
`define BPSS_BUDGET_X10_HIGH 8'hcd
`define BPSS_CLKSEL_OFF 2'h0
`define BPSS_CLKSEL_4M 2'h1
`define BPSS_CLKSEL_8M 2'h2
`define BPSS_CLKSEL_16M 2'h3
`endif

// ===== bpss_sequencer.sv
// Supervisory power state sequencer of a bus transceiver: states, rail
// enables, host clock selection, host reset and power-warning outputs.
// Assumes comparator flags arrive asynchronously and one 100 MHz clock.
// Functional notes
// (R1) Strap floating, high or above 250 kohm: slope 0.5 mA/ms, 30 mA, 10.6 mA.
// (R2) Strap below 2 kohm to ground: slope 1 mA/ms, 60 mA, 20.5 mA.
// (R3) Strap 10 to 93.1 kohm: resistor-defined slope and limit.
// (R4) Host reset low on low supply, fixed buck down, or thermal shutdown.
// (R5) Power warning low at once when filtered supply below 14 V.
// (R6) Bus low for 2 ms enters Stand-By with power warning low.
// (R7) Host reset low whenever filtered supply below 12 V.
// (R8) Stand-By from Start-Up: 4 MHz clock, fixed rail, rails start, comms.
// (R9) Stand-By from Normal keeps oscillator, fixed rail and comms active.
// (R10) Stand-By from Normal: 4 MHz on oscillator fault, else crystal clock.
// (R11) Stand-By from Normal keeps rails only without rail fault cause.
// (R12) Normal outputs 8 or 16 MHz per clock select input.
// (R13) Thermal warning drives power warning low.
// (R14) Thermal shutdown forces Reset, supplies off, held while flag stays.
// (R15) Shutdown cleared: Start-Up, then Stand-By after rail up and trim.
// (R16) Normal only after warning clears and all voltages good.
// (R17) Filtered supply at 10 V leaves Reset, enables fixed buck.
// (R18) Start-Up: fixed rail above 2.8 V loads trim, then Stand-By.
// (R19) Stand-By enables adjustable buck and 20 V rail above upper threshold.
// (R20) All monitors good enters Normal, releases power warning.
// (R21) Filtered supply below lower threshold stops adjustable buck and 20 V.
// (R22) Below 6.5 V fixed buck off; fixed rail below 2.8 V enters Reset.
// (R23) Clock select low asks 8 MHz, high asks 16 MHz.
// (R24) Adjustable buck runs only while its active-low enable is low.
// (R25) 20 V regulator runs only while its active-low enable is low.
// (R26) Reset and Start-Up keep clock, rails and comms inactive.
// (R27) Reset and warning are open-drain: released, never driven high.
`timescale 1ns/1ns
`include "bpss_regs.svh"
module bpss_sequencer #(
    parameter int BUS_FILTER_CYC = `BPSS_BUS_FILTER_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic busVoltageOk, // bus above low threshold
    input wire logic filteredAbove10v, // filtered supply above 10 V
    input wire logic filteredAbove14v, // filtered supply above 14 V
    input wire logic filteredAbove12v, // filtered supply above 12 V
    input wire logic filteredAbove6v5, // filtered supply above 6.5 V
    input wire logic filteredUpperOk, // above upper threshold
    input wire logic filteredLowerOk, // above lower threshold
    input wire logic fixedRailOk, // fixed rail above 2.8 V
    input wire logic adjustableRailOk, // adjustable rail monitor good
    input wire logic auxRailOk, // 20 V rail monitor good
    input wire logic oscillatorOk, // crystal oscillator good
    input wire logic thermalWarning, // thermal warning flag
    input wire logic thermalShutdown, // thermal shutdown flag
    input wire logic trimLoadDone, // trim memory read complete
    input wire logic hostClockSelect, // low 8 MHz, high 16 MHz
    input wire logic strapFloatOrHigh, // strap open, high or above 250 kohm
    input wire logic strapHardLow, // strap below 2 kohm to ground
    input wire logic adjBuckEnable_n, // external adjustable buck enable
    input wire logic auxRegEnable_n, // external 20 V regulator enable
    output logic hostReset_n_o, // open-drain output value, always low
    output logic hostReset_n_oe, // high while pulling host reset low
    output logic powerWarning_n_o, // open-drain output value, always low
    output logic powerWarning_n_oe, // high while pulling warning low
    output logic fixedBuckOn, // fixed buck enable
    output logic adjustableBuckOn, // adjustable buck enable
    output logic auxRegOn, // 20 V regulator enable
    output logic trimLoad, // request trim memory load
    output logic oscillatorOn, // crystal oscillator enable
    output logic [1:0] hostClockSel, // host clock source code
    output logic commActive, // bus communication allowed
    output logic [1:0] limitMode, // selected current-limit mode
    output logic [7:0] slopeX10, // slope in 0.1 mA/ms, 0 if by resistor
    output logic [7:0] startupLimitMa, // start-up current, 0 if by resistor
    output logic [7:0] budgetX10 // normal budget in 0.1 mA, 0 if by resistor
);
    localparam int NFLAG = 19;
    logic [NFLAG-1:0] rawFlags;
    logic [NFLAG-1:0] syncFlags;
    // Synchronised comparator and pin levels
    logic busOk;
    logic f10;
    logic f14;
    logic f12;
    logic f6v5;
    logic fUp;
    logic fLo;
    logic fixedOk;
    logic adjOk;
    logic auxOk;
    logic oscOk;
    logic tw;
    logic thermal_shutdown;
    logic trimDone;
    logic clkSel16;
    logic strapHigh;
    logic strapLow;
    logic adjEnable_n;
    logic auxEnable_n;
    logic busLost;
    bpss_pkg::state_type state;
    bpss_pkg::state_type next_state;
    logic fromNormal;
    logic next_fromNormal;
    logic oscFault;
    logic next_oscFault;
    logic railFault;
    logic next_railFault;
    logic fixedBuck;
    logic next_fixedBuck;
    logic next_hostReset_n_oe;
    logic next_powerWarning_n_oe;
    logic next_adjustableBuckOn;
    logic next_auxRegOn;
    logic next_trimLoad;
    logic next_oscillatorOn;
    logic [1:0] next_hostClockSel;
    logic next_commActive;
    logic [1:0] next_limitMode;
    logic [7:0] next_slopeX10;
    logic [7:0] next_startupLimitMa;
    logic [7:0] next_budgetX10;
    // Entry to Normal needs the bus; staying there leaves bus dips to the filter
    logic allGood;
    logic keepGood;

    initial begin
        if (BUS_FILTER_CYC < 1) begin
            $error("bpss_sequencer: BUS_FILTER_CYC must be at least 1");
        end
    end

    // Pins and comparators alike pass the two-flop synchroniser
    assign rawFlags = {busVoltageOk, filteredAbove10v, filteredAbove14v, filteredAbove12v,
                       filteredAbove6v5, filteredUpperOk, filteredLowerOk, fixedRailOk,
                       adjustableRailOk, auxRailOk, oscillatorOk, thermalWarning,
                       thermalShutdown, trimLoadDone, hostClockSelect, strapFloatOrHigh,
                       strapHardLow,
                       adjBuckEnable_n, auxRegEnable_n};

    bpss_sync #(.WIDTH(NFLAG)) uSync (
        .clk_sys(clk_sys),
        .srst(srst),
        .din(rawFlags),
        .dout(syncFlags)
    );

    assign {busOk, f10, f14, f12, f6v5, fUp, fLo, fixedOk, adjOk, auxOk, oscOk,
            tw, thermal_shutdown, trimDone, clkSel16, strapHigh, strapLow,
            adjEnable_n, auxEnable_n} = syncFlags;

    bpss_bus_filter #(.FILTER_CYC(BUS_FILTER_CYC)) uBusFilter (
        .clk_sys(clk_sys),
        .srst(srst),
        .busLow(!busOk),
        .busLost(busLost) // R6
    );

    // Crystal clock code for the selected rate
    function automatic logic [1:0] xtalCode(input logic sel16);
        xtalCode = sel16 ? `BPSS_CLKSEL_16M : `BPSS_CLKSEL_8M; // R12 R23
    endfunction

    assign keepGood = fUp && adjOk && auxOk && oscOk && !tw;
    assign allGood = busOk && keepGood;

    // State transitions
    always_comb begin
        next_state = state;
        next_fromNormal = fromNormal;
        next_oscFault = oscFault;
        next_railFault = railFault;
        next_fixedBuck = fixedBuck;
        case (state)
            bpss_pkg::ST_RESET: begin
                next_fixedBuck = 1'b0;
                if (!thermal_shutdown && f10) begin // R14 R17
                    next_state = bpss_pkg::ST_STARTUP;
                    next_fixedBuck = 1'b1;
                end
            end
            bpss_pkg::ST_STARTUP: begin
                if (fixedOk && trimDone) begin // R15 R18
                    next_state = bpss_pkg::ST_STANDBY;
                    next_fromNormal = 1'b0;
                    next_oscFault = 1'b0;
                    next_railFault = 1'b0;
                end
            end
            bpss_pkg::ST_STANDBY: begin
                if (allGood && !busLost) begin // R16 R20
                    next_state = bpss_pkg::ST_NORMAL;
                end
            end
            bpss_pkg::ST_NORMAL: begin
                if (!keepGood || busLost) begin // R6 R13
                    next_state = bpss_pkg::ST_STANDBY;
                    next_fromNormal = 1'b1;
                    next_oscFault = !oscOk; // R10
                    next_railFault = !adjOk || !auxOk; // R11
                end
            end
            default: begin
                next_state = bpss_pkg::ST_RESET;
            end
        endcase
        if (state != bpss_pkg::ST_RESET && !f6v5) begin
            next_fixedBuck = 1'b0; // R22
        end
        if (state != bpss_pkg::ST_RESET && (!fixedBuck || !f6v5) && !fixedOk) begin
            next_state = bpss_pkg::ST_RESET; // R22
        end
        if (thermal_shutdown) begin
            next_state = bpss_pkg::ST_RESET; // R14
            next_fixedBuck = 1'b0;
        end
        if (srst) begin
            next_state = bpss_pkg::ST_RESET;
            next_fromNormal = 1'b0;
            next_oscFault = 1'b0;
            next_railFault = 1'b0;
            next_fixedBuck = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        state <= next_state;
        fromNormal <= next_fromNormal;
        oscFault <= next_oscFault;
        railFault <= next_railFault;
        fixedBuck <= next_fixedBuck;
    end

    // Outputs derived from the next state so each leaves a flip-flop
    always_comb begin
        logic active;
        logic inNormal;
        logic railsAllowed;
        active = (next_state == bpss_pkg::ST_STANDBY) || (next_state == bpss_pkg::ST_NORMAL);
        inNormal = next_state == bpss_pkg::ST_NORMAL;
        next_commActive = active; // R8 R9 R26
        // Rails: start in Stand-By above upper threshold, drop below lower one
        railsAllowed = active && fLo && !(next_fromNormal && next_railFault && !inNormal); // R11 R21
        next_adjustableBuckOn = railsAllowed && (fUp || adjustableBuckOn) && !adjEnable_n; // R19 R24
        next_auxRegOn = railsAllowed && (fUp || auxRegOn) && !auxEnable_n; // R19 R25
        next_oscillatorOn = inNormal || (active && next_fromNormal); // R9 R26
        if (!active) begin
            next_hostClockSel = `BPSS_CLKSEL_OFF; // R26
        end else if (inNormal) begin
            next_hostClockSel = xtalCode(clkSel16); // R12
        end else if (next_fromNormal && !next_oscFault) begin
            next_hostClockSel = xtalCode(clkSel16); // R10
        end else begin
            next_hostClockSel = `BPSS_CLKSEL_4M; // R8 R10
        end
        next_trimLoad = (state == bpss_pkg::ST_STARTUP) && fixedOk && !trimDone; // R18
        // Open-drain: enable pulls low, release otherwise
        next_hostReset_n_oe = !active || !f12 || thermal_shutdown || !fixedBuck; // R4 R7 R27
        next_powerWarning_n_oe = !inNormal || !f14 || tw || busLost; // R5 R6 R13 R20 R27
        if (strapLow) begin
            next_limitMode = `BPSS_SLOPE_HIGH; // R2
            next_slopeX10 = `BPSS_SLOPE_X10_HIGH;
            next_startupLimitMa = `BPSS_STARTUP_MA_HIGH;
            next_budgetX10 = `BPSS_BUDGET_X10_HIGH;
        end else if (strapHigh) begin
            next_limitMode = `BPSS_SLOPE_LOW; // R1
            next_slopeX10 = `BPSS_SLOPE_X10_LOW;
            next_startupLimitMa = `BPSS_STARTUP_MA_LOW;
            next_budgetX10 = `BPSS_BUDGET_X10_LOW;
        end else begin
            next_limitMode = `BPSS_SLOPE_RES; // R3
            next_slopeX10 = 8'h00;
            next_startupLimitMa = 8'h00;
            next_budgetX10 = 8'h00;
        end
        if (srst) begin
            next_commActive = 1'b0;
            next_adjustableBuckOn = 1'b0;
            next_auxRegOn = 1'b0;
            next_oscillatorOn = 1'b0;
            next_hostClockSel = `BPSS_CLKSEL_OFF;
            next_trimLoad = 1'b0;
            next_hostReset_n_oe = 1'b1;
            next_powerWarning_n_oe = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        commActive <= next_commActive;
        adjustableBuckOn <= next_adjustableBuckOn;
        auxRegOn <= next_auxRegOn;
        oscillatorOn <= next_oscillatorOn;
        hostClockSel <= next_hostClockSel;
        trimLoad <= next_trimLoad;
        hostReset_n_oe <= next_hostReset_n_oe;
        powerWarning_n_oe <= next_powerWarning_n_oe;
        hostReset_n_o <= 1'b0;
        powerWarning_n_o <= 1'b0;
        fixedBuckOn <= next_fixedBuck;
        limitMode <= next_limitMode;
        slopeX10 <= next_slopeX10;
        startupLimitMa <= next_startupLimitMa;
        budgetX10 <= next_budgetX10;
    end
endmodule

// ===== bpss_sequencer_tb.sv
// Self-checking bench of the bus power state sequencer against a state model.
// Assumes outputs settle within twelve cycles of an input change.
`timescale 1ns/1ns
`include "bpss_regs.svh"
module bpss_sequencer_tb;
    localparam int FILT = 20;
    localparam int BUS = 0, F10 = 1, F14 = 2, F12 = 3, F65 = 4, UP = 5, LO = 6, FIX = 7, ADJ = 8, AUX = 9;
    localparam int OSC = 10, TW = 11, THERMAL_SHUTDOWN = 12, TRIM = 13, AEN = 14, XEN = 15, SFL = 16, SHL = 17, SEL = 18;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [18:0] fl = '0;
    logic [18:0] nx = '0;
    logic selPin, rstPin, warnPin, running, rstOe, rstO, warnOe, warnO, fixOn, adjOn, auxOn, trimReq, oscOn, comm;
    logic [1:0] clkSel, limMode;
    logic [7:0] slope, suMa, budget;
    logic [7:0] rnd = 8'h3c;
    wire logic [8:0] vec = {rstPin, warnPin, fixOn, adjOn, auxOn, oscOn, comm, clkSel};
    int bad_count = 0, comparisons = 0, cyc = 0, st = 0, fromN = 0, oc = 0, rf = 0;
    int faults [4] = '{OSC, ADJ, AUX, TW};
    always #5 clk_sys = ~clk_sys;
    bpss_sequencer #(.BUS_FILTER_CYC(FILT)) u_bpss_sequencer (.clk_sys(clk_sys), .srst(srst),
        .busVoltageOk(fl[BUS]), .filteredAbove10v(fl[F10]), .filteredAbove14v(fl[F14]), .filteredAbove12v(fl[F12]),
        .filteredAbove6v5(fl[F65]), .filteredUpperOk(fl[UP]), .filteredLowerOk(fl[LO]), .fixedRailOk(fl[FIX]),
        .adjustableRailOk(fl[ADJ]), .auxRailOk(fl[AUX]), .oscillatorOk(fl[OSC]), .thermalWarning(fl[TW]),
        .thermalShutdown(fl[THERMAL_SHUTDOWN]), .trimLoadDone(fl[TRIM]), .hostClockSelect(selPin), .strapFloatOrHigh(fl[SFL]),
        .strapHardLow(fl[SHL]), .adjBuckEnable_n(fl[AEN]), .auxRegEnable_n(fl[XEN]), .hostReset_n_o(rstO),
        .hostReset_n_oe(rstOe), .powerWarning_n_o(warnO), .powerWarning_n_oe(warnOe), .fixedBuckOn(fixOn),
        .adjustableBuckOn(adjOn), .auxRegOn(auxOn), .trimLoad(trimReq), .oscillatorOn(oscOn), .hostClockSel(clkSel),
        .commActive(comm), .limitMode(limMode), .slopeX10(slope), .startupLimitMa(suMa), .budgetX10(budget));
    bpss_host_model u_bpss_host_model (.wantFast(fl[SEL]), .resetOe(rstOe), .resetVal(rstO), .warnOe(warnOe),
        .warnVal(warnO), .hostClockSelect(selPin), .hostReset_n(rstPin), .powerWarning_n(warnPin),
        .hostRunning(running));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [8:0] expv();
        logic r;
        int c;
        r = st >= 2 && nx[LO] && nx[UP] && (st == 3 || rf == 0);
        c = st < 2 ? 0 : (st == 3 || (fromN == 1 && oc == 0)) ? (nx[SEL] ? 3 : 2) : 1;
        return {st >= 2 && nx[F12], st == 3 && nx[F14] && !nx[TW], st != 0, r && !nx[AEN], r && !nx[XEN],
            st == 3 || (st == 2 && fromN == 1), st >= 2, c[1:0]};
    endfunction
    // Reference state walk: 0 Reset, 1 Start-Up, 2 Stand-By, 3 Normal
    task automatic model();
        logic good;
        repeat (4) begin
            good = nx[BUS] && nx[UP] && nx[ADJ] && nx[AUX] && nx[OSC] && !nx[TW];
            if (nx[THERMAL_SHUTDOWN] || (st != 0 && !nx[FIX] && !nx[F65])) st = 0;
            else if (st == 0 && nx[F10]) st = 1;
            else if (st == 1 && nx[FIX] && nx[TRIM]) begin
                st = 2;
                fromN = 0;
                rf = 0;
            end else if (st == 2 && good) st = 3;
            else if (st == 3 && !good) begin
                st = 2;
                fromN = 1;
                oc = !nx[OSC];
                rf = !nx[ADJ] || !nx[AUX];
            end
        end
    endtask
    task automatic step(input logic [8:0] mask);
        @(posedge clk_sys);
        fl <= nx;
        model();
        repeat (12) @(posedge clk_sys);
        #1;
        chk(32'(vec & mask), 32'(expv() & mask), "state outputs");
    endtask
    task automatic dip(input int n);
        @(posedge clk_sys);
        fl[BUS] <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
        chk(32'(warnPin), 32'(n < FILT), "warning during bus dip");
        @(posedge clk_sys);
        fl[BUS] <= 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        chk(32'(vec), 32'(expv()), "after bus dip");
    endtask
    initial begin
        logic [25:0] strapTbl [3];
        strapTbl = '{{2'(bpss_pkg::LIM_LOW), `BPSS_SLOPE_X10_LOW, `BPSS_STARTUP_MA_LOW, `BPSS_BUDGET_X10_LOW},
            {2'(bpss_pkg::LIM_HIGH), `BPSS_SLOPE_X10_HIGH, `BPSS_STARTUP_MA_HIGH, `BPSS_BUDGET_X10_HIGH},
            {2'(bpss_pkg::LIM_RES), 24'h0}};
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        step(9'h1ff);
        nx[F65] = 1'b1; nx[F10] = 1'b1; nx[F12] = 1'b1; nx[F14] = 1'b1;
        step(9'h1ff);
        nx[FIX] = 1'b1;
        step(9'h1ff);
        chk(32'(trimReq), 32'h1, "trim load request");
        nx[TRIM] = 1'b1;
        step(9'h1ff);
        nx[UP] = 1'b1; nx[LO] = 1'b1;
        step(9'h1ff);
        nx[BUS] = 1'b1; nx[ADJ] = 1'b1; nx[AUX] = 1'b1; nx[OSC] = 1'b1;
        step(9'h1ff);
        nx[SEL] = 1'b1;
        step(9'h1ff);
        for (int k = 0; k < 4; k++) begin
            nx[faults[k]] = !nx[faults[k]];
            step(9'h1ff);
            nx[faults[k]] = !nx[faults[k]];
            step(9'h1ff);
        end
        rnd = lfsr(rnd);
        dip(int'(rnd % 8'd12) + 2);
        dip(FILT + 10);
        nx[F14] = 1'b0;
        step(9'h080);
        nx[F12] = 1'b0;
        step(9'h100);
        chk(32'(running), 32'h0, "host held in reset");
        nx[F14] = 1'b1; nx[F12] = 1'b1; nx[AEN] = 1'b1;
        step(9'h1ff);
        nx[AEN] = 1'b0; nx[XEN] = 1'b1;
        step(9'h1ff);
        nx[XEN] = 1'b0; nx[LO] = 1'b0;
        step(9'h1ff);
        nx[LO] = 1'b1; nx[THERMAL_SHUTDOWN] = 1'b1;
        step(9'h1ff);
        nx[THERMAL_SHUTDOWN] = 1'b0;
        step(9'h1ff);
        nx[F65] = 1'b0; nx[F10] = 1'b0; nx[F12] = 1'b0; nx[F14] = 1'b0; nx[LO] = 1'b0; nx[UP] = 1'b0; nx[FIX] = 1'b0;
        step(9'h1ff);
        for (int k = 0; k < 3; k++) begin
            nx[SFL] = (k == 0);
            nx[SHL] = (k == 1);
            step(9'h1ff);
            chk(32'({limMode, slope, suMa, budget}), 32'(strapTbl[k]), "strap decode");
        end
        print_verdict();
    end
endmodule

// ===== bpss_sync.sv
// Two-flop synchroniser for a vector of asynchronous comparator flags.
// Assumes flags are quasi-static levels from the analog side.
`timescale 1ns/1ns
module bpss_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [WIDTH-1:0] din, // asynchronous levels
    output logic [WIDTH-1:0] dout // synchronised levels
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    initial begin
        if (WIDTH < 1) begin
            $error("bpss_sync: WIDTH must be positive");
        end
    end

    always_comb begin
        next_stage1 = srst ? '0 : din;
        next_dout = srst ? '0 : stage1;
    end

    always_ff @(posedge clk_sys) begin
        stage1 <= next_stage1;
        dout <= next_dout;
    end
endmodule
